// file: cpwd_map.vh
// register map, field positions and reset values of the counter array
//
// Overview of operation
// - frequency output toggles, adds high byte to low
// - compare, flip and width bits pick frequency
// - 8-bit width: high on match, low on overflow
// - low-byte wrap reloads compare low from high
// - compare plus width, no flip, no 16: 8-bit
// - low write clears compare enable, high sets
// - 8-bit duty is 256 minus high over 256
// - 16-bit width: high on match, low on overflow
// - compare, width and sixteen bits pick 16-bit
// - watchdog: module 4 high vs counter high
// - reset: watchdog on, divide by 12, zeros
// - watchdog freezes counter, timebase, idle, module 4
// - watchdog keeps counter on; run bit reads software
// - update write loads counter high plus offset
// - reset on low overflow while update matches high
// - writing module 4 flag one forces reset
// - enable or lock enables; lock holds until reset
// - timeout 256 times offset plus 256 minus low
// - timebase select chooses one of six sources
`ifndef CPWD_MAP_VH
`define CPWD_MAP_VH

`define CPWD_A_CTRL     8'h00
`define CPWD_A_MODE     8'h01
`define CPWD_A_CNTL     8'h02
`define CPWD_A_CNTH     8'h03
`define CPWD_A_CPM      8'h08
`define CPWD_A_CPL      8'h10
`define CPWD_A_CPH      8'h18

`define CPWD_CTRL_CF    7
`define CPWD_CTRL_CR    6
`define CPWD_MODE_IDLE_SUSPEND  7
`define CPWD_MODE_WDOG_ENABLE  6
`define CPWD_MODE_WDOG_LOCK 5
`define CPWD_MODE_CPS_H 3
`define CPWD_MODE_CPS_L 1
`define CPWD_MODE_ECF   0

`define CPWD_CPM_W16    7
`define CPWD_CPM_ECOM   6
`define CPWD_CPM_MAT    3
`define CPWD_CPM_TOG    2
`define CPWD_CPM_PWM    1

`define CPWD_MODE_RST   8'h40
`define CPWD_CPM_RST    8'h00
`define CPWD_CPM_TIMER  8'h48
`define CPWD_WD_MODULE  4

`define CPWD_TB_DIV12   3'h0
`define CPWD_TB_DIV4    3'h1
`define CPWD_TB_TMR0    3'h2
`define CPWD_TB_ECI     3'h3
`define CPWD_TB_SYS     3'h4
`define CPWD_TB_EXT8    3'h5

`define CPWD_DIV12      4'hc
`define CPWD_DIV4       4'h4
`define CPWD_EXT_DIV    3'h7

`endif

// file: cpwd_ccm.v
// one capture/compare module in its output modes
`timescale 1ns/10ps
`default_nettype none
`include "cpwd_map.vh"
module cpwd_ccm (
  input  wire        clk,
  input  wire        rst,
  input  wire        tick,
  input  wire [15:0] cnt_nx,
  input  wire        wr_mode,
  input  wire        wr_lo,
  input  wire        wr_hi,
  input  wire [7:0]  wdata,
  input  wire [7:0]  hi_data,
  input  wire        wd_mode,
  input  wire        flag_wr,
  input  wire        flag_val,
  output reg  [7:0]  mode_reg,
  output reg  [7:0]  lo_reg,
  output reg  [7:0]  hi_reg,
  output reg         pin_reg,
  output reg         flag_reg
);
  wire [7:0] mode_eff;
  wire       ecom;
  wire       fout;
  wire       pwm8;
  wire       pwm16;
  wire       ovf8;
  wire       ovf16;
  wire       hit8;
  wire       hit16;
  wire       hw_set;

  // watchdog forces software timer mode
  assign mode_eff = wd_mode ? `CPWD_CPM_TIMER : mode_reg;
  assign ecom  = mode_eff[`CPWD_CPM_ECOM];
  assign fout  = ecom & mode_eff[`CPWD_CPM_TOG] & mode_eff[`CPWD_CPM_PWM];
  assign pwm8  = ecom & ~mode_eff[`CPWD_CPM_TOG] & mode_eff[`CPWD_CPM_PWM]
                 & ~mode_eff[`CPWD_CPM_W16];
  assign pwm16 = ecom & ~mode_eff[`CPWD_CPM_TOG] & mode_eff[`CPWD_CPM_PWM]
                 & mode_eff[`CPWD_CPM_W16];
  assign ovf8  = cnt_nx[7:0] == 8'h00;
  assign ovf16 = cnt_nx == 16'h0000;
  assign hit8  = cnt_nx[7:0] == lo_reg;
  assign hit16 = cnt_nx == {hi_reg, lo_reg};
  assign hw_set = tick & ecom & mode_eff[`CPWD_CPM_MAT] & ~wd_mode
                  & (pwm8 ? hit8 : hit16);

  always @(posedge clk) begin
    if (rst) begin
      mode_reg <= `CPWD_CPM_RST;
      lo_reg   <= 8'h00;
      hi_reg   <= 8'h00;
      pin_reg  <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      // hardware set wins over a software clear
      if (hw_set)
        flag_reg <= 1'b1;
      else if (flag_wr)
        flag_reg <= flag_val;
      if (wr_mode && !wd_mode)
        mode_reg <= wdata;
      else if (wr_hi)
        mode_reg[`CPWD_CPM_ECOM] <= 1'b1;
      else if (wr_lo)
        mode_reg[`CPWD_CPM_ECOM] <= 1'b0;
      if (wr_hi)
        hi_reg <= hi_data;
      if (wr_lo)
        lo_reg <= wdata;
      else if (tick && fout && hit8)
        lo_reg <= lo_reg + hi_reg;
      else if (tick && pwm8 && ovf8)
        lo_reg <= hi_reg;
      if (mode_eff[`CPWD_CPM_PWM] && !mode_eff[`CPWD_CPM_TOG] && !ecom)
        pin_reg <= 1'b0;
      else if (tick && fout && hit8)
        pin_reg <= ~pin_reg;
      else if (tick && pwm8) begin
        // a zero high byte keeps the output high through overflow
        if (ovf8)
          pin_reg <= hi_reg == 8'h00;
        else if (hit8)
          pin_reg <= 1'b1;
      end else if (tick && pwm16) begin
        if (ovf16)
          pin_reg <= {hi_reg, lo_reg} == 16'h0000;
        else if (hit16)
          pin_reg <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: cpwd_top.v
// counter array with output-mode modules and watchdog on module 4
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "cpwd_map.vh"
module cpwd_top #(
  parameter N_MOD = 5
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [7:0]       reg_addr,
  input  wire [7:0]       reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [7:0]       reg_rdata,
  input  wire             tmr0_ovf,
  input  wire             cpu_idle,
  input  wire             ext_count_pin,
  input  wire             ext_osc_pin,
  output wire [N_MOD-1:0] module_output_pin,
  output reg              wdog_reset
);
  reg  [3:0]  div_cnt_reg;
  reg         tick12_reg;
  reg         tick4_reg;
  reg  [1:0]  d4_cnt_reg;
  reg  [1:0]  eci_sync_reg;
  reg         eci_last_reg;
  reg  [1:0]  osc_sync_reg;
  reg         osc_last_reg;
  reg  [2:0]  osc_div_reg;
  reg  [15:0] cnt_reg;
  reg         cr_reg;
  reg         cf_reg;
  reg  [7:0]  mode_reg;
  reg         src_tick;
  reg  [7:0]  rd_next;

  wire        wd_en;
  wire        run;
  wire        tick;
  wire [15:0] cnt_nx;
  wire [2:0]  tb_sel;
  wire        eci_fall;
  wire        osc_rise;
  wire        wr_ctrl;
  wire        wr_mode;
  wire        wr_cntl;
  wire        wr_cnth;
  wire [7:0]  mode_q  [0:N_MOD-1];
  wire [7:0]  lo_q    [0:N_MOD-1];
  wire [7:0]  hi_q    [0:N_MOD-1];
  wire [N_MOD-1:0] flag_q;
  wire [N_MOD-1:0] pin_q;
  wire        wd_hit;
  wire        wd_force;

  assign wd_en = mode_reg[`CPWD_MODE_WDOG_ENABLE] | mode_reg[`CPWD_MODE_WDOG_LOCK];
  assign run   = cr_reg | wd_en;
  assign tb_sel = mode_reg[`CPWD_MODE_CPS_H:`CPWD_MODE_CPS_L];
  assign eci_fall = eci_last_reg & ~eci_sync_reg[1];
  assign osc_rise = ~osc_last_reg & osc_sync_reg[1];
  assign tick = run & src_tick
                & ~(mode_reg[`CPWD_MODE_IDLE_SUSPEND] & cpu_idle);
  assign cnt_nx = cnt_reg + 16'h0001;

  assign wr_ctrl = reg_wr && reg_addr == `CPWD_A_CTRL;
  assign wr_mode = reg_wr && reg_addr == `CPWD_A_MODE;
  assign wr_cntl = reg_wr && reg_addr == `CPWD_A_CNTL && !wd_en;
  assign wr_cnth = reg_wr && reg_addr == `CPWD_A_CNTH && !wd_en;
  assign module_output_pin = pin_q;

  // timebase dividers and synchronised edge sources
  always @(posedge clk) begin
    if (rst) begin
      div_cnt_reg  <= 4'h0;
      tick12_reg   <= 1'b0;
      d4_cnt_reg   <= 2'h0;
      tick4_reg    <= 1'b0;
      eci_sync_reg <= 2'h3;
      eci_last_reg <= 1'b1;
      osc_sync_reg <= 2'h0;
      osc_last_reg <= 1'b0;
      osc_div_reg  <= 3'h0;
    end else begin
      if (div_cnt_reg == `CPWD_DIV12 - 4'h1) begin
        div_cnt_reg <= 4'h0;
        tick12_reg  <= 1'b1;
      end else begin
        div_cnt_reg <= div_cnt_reg + 4'h1;
        tick12_reg  <= 1'b0;
      end
      d4_cnt_reg   <= d4_cnt_reg + 2'h1;
      tick4_reg    <= d4_cnt_reg == 2'h3;
      eci_sync_reg <= {eci_sync_reg[0], ext_count_pin};
      eci_last_reg <= eci_sync_reg[1];
      osc_sync_reg <= {osc_sync_reg[0], ext_osc_pin};
      osc_last_reg <= osc_sync_reg[1];
      if (osc_rise)
        osc_div_reg <= osc_div_reg + 3'h1;
    end
  end

  always @* begin
    case (tb_sel)
      `CPWD_TB_DIV12: src_tick = tick12_reg;
      `CPWD_TB_DIV4:  src_tick = tick4_reg;
      `CPWD_TB_TMR0:  src_tick = tmr0_ovf;
      `CPWD_TB_ECI:   src_tick = eci_fall;
      `CPWD_TB_SYS:   src_tick = 1'b1;
      `CPWD_TB_EXT8:  src_tick = osc_rise && osc_div_reg == `CPWD_EXT_DIV;
      default:        src_tick = 1'b0;
    endcase
  end

  // counter, run bit, overflow flag and mode register
  always @(posedge clk) begin
    if (rst) begin
      cnt_reg  <= 16'h0000;
      cr_reg   <= 1'b0;
      cf_reg   <= 1'b0;
      mode_reg <= `CPWD_MODE_RST;
    end else begin
      if (wr_cntl)
        cnt_reg[7:0] <= reg_wdata;
      else if (wr_cnth)
        cnt_reg[15:8] <= reg_wdata;
      else if (tick)
        cnt_reg <= cnt_nx;
      if (tick && cnt_nx == 16'h0000)
        cf_reg <= 1'b1;
      else if (wr_ctrl)
        cf_reg <= reg_wdata[`CPWD_CTRL_CF];
      if (wr_ctrl)
        cr_reg <= reg_wdata[`CPWD_CTRL_CR];
      if (wr_mode) begin
        if (!wd_en)
          mode_reg <= {reg_wdata[7:5], 1'b0, reg_wdata[3:0]};
        else if (!mode_reg[`CPWD_MODE_WDOG_LOCK])
          mode_reg[`CPWD_MODE_WDOG_ENABLE] <= reg_wdata[`CPWD_MODE_WDOG_ENABLE];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_MOD; gi = gi + 1) begin : g_mod
      localparam [7:0] MOD_IDX = gi;
      wire is_wd;
      wire wr_lo;
      wire wr_hi;
      assign is_wd = (gi == `CPWD_WD_MODULE) && wd_en;
      assign wr_lo = reg_wr && reg_addr == `CPWD_A_CPL + MOD_IDX;
      assign wr_hi = reg_wr && reg_addr == `CPWD_A_CPH + MOD_IDX;
      cpwd_ccm u_ccm (
        .clk      (clk),
        .rst      (rst),
        .tick     (tick),
        .cnt_nx   (cnt_nx),
        .wr_mode  (reg_wr && reg_addr == `CPWD_A_CPM + MOD_IDX),
        .wr_lo    (wr_lo),
        .wr_hi    (wr_hi),
        .wdata    (reg_wdata),
        .hi_data  (is_wd ? cnt_reg[15:8] + lo_q[gi] : reg_wdata),
        .wd_mode  (is_wd),
        .flag_wr  (wr_ctrl),
        .flag_val (reg_wdata[gi]),
        .mode_reg (mode_q[gi]),
        .lo_reg   (lo_q[gi]),
        .hi_reg   (hi_q[gi]),
        .pin_reg  (pin_q[gi]),
        .flag_reg (flag_q[gi])
      );
    end
  endgenerate

  // timeout: low byte overflows while update byte equals counter high
  assign wd_hit = wd_en && tick && cnt_reg[7:0] == 8'hff
                  && hi_q[`CPWD_WD_MODULE] == cnt_reg[15:8];
  assign wd_force = wd_en && wr_ctrl && reg_wdata[`CPWD_WD_MODULE];

  always @(posedge clk) begin
    if (rst)
      wdog_reset <= 1'b0;
    else
      wdog_reset <= wd_hit | wd_force;
  end

  // read mux, data one cycle after the strobe
  always @* begin
    rd_next = 8'h00;
    if (reg_addr == `CPWD_A_CTRL)
      rd_next = {cf_reg, cr_reg, 1'b0, flag_q[4:0]};
    else if (reg_addr == `CPWD_A_MODE)
      rd_next = mode_reg;
    else if (reg_addr == `CPWD_A_CNTL)
      rd_next = cnt_reg[7:0];
    else if (reg_addr == `CPWD_A_CNTH)
      rd_next = cnt_reg[15:8];
    else if (reg_addr >= `CPWD_A_CPM && reg_addr < `CPWD_A_CPM + N_MOD)
      rd_next = mode_q[reg_addr[2:0]];
    else if (reg_addr >= `CPWD_A_CPL && reg_addr < `CPWD_A_CPL + N_MOD)
      rd_next = lo_q[reg_addr[2:0]];
    else if (reg_addr >= `CPWD_A_CPH && reg_addr < `CPWD_A_CPH + N_MOD)
      rd_next = hi_q[reg_addr[2:0]];
  end

  always @(posedge clk) begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_next;
    else
      reg_rdata <= 8'h00;
  end
endmodule
`default_nettype wire

// file: cpwd_dummy_guard.v
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: cpwd_top_sva.sv
// checker for the counter array top ports
`timescale 1ns/10ps
`default_nettype none
`include "cpwd_map.vh"
module cpwd_top_chk #(
  parameter N_MOD = 5
) (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic [7:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata,
  input wire logic [N_MOD-1:0] module_output_pin,
  input wire logic             wdog_reset
);
  logic       en_reg;
  logic       lock_reg;
  logic [7:0] m0_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // mirror of watchdog state and module 0 mode
  always_ff @(posedge clk) begin
    if (rst) begin
      en_reg   <= 1'b1;
      lock_reg <= 1'b0;
      m0_reg   <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `CPWD_A_MODE && !lock_reg) begin
        en_reg   <= en_reg ? reg_wdata[6] : (reg_wdata[6] | reg_wdata[5]);
        lock_reg <= en_reg ? 1'b0 : reg_wdata[5];
      end
      if (reg_addr == `CPWD_A_CPM) m0_reg <= reg_wdata;
      if (reg_addr == `CPWD_A_CPL) m0_reg[6] <= 1'b0;
      if (reg_addr == `CPWD_A_CPH) m0_reg[6] <= 1'b1;
    end
  end
  reset_clear_a: assert property (disable iff (1'b0) rst |=>
    reg_rdata == 8'h00 && module_output_pin == '0 && !wdog_reset) else $error("outputs not cleared by reset");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read cycle");
  force_reset_a: assert property (reg_wr && reg_addr == `CPWD_A_CTRL && reg_wdata[4] && en_reg |=> wdog_reset)
    else $error("flag write gave no watchdog reset");
  reset_source_a: assert property (wdog_reset |-> $past(en_reg) || $past(en_reg, 2))
    else $error("watchdog reset while disabled");
  zero_duty_a: assert property (m0_reg[1] && !m0_reg[2] && !m0_reg[6] && $past(m0_reg) == m0_reg
    |-> !module_output_pin[0]) else $error("pwm output high with compare off");
  mode_readback_a: assert property (reg_rd && reg_addr == `CPWD_A_CPM |=> reg_rdata == $past(m0_reg))
    else $error("module mode readback wrong");
  wd_state_a: assert property (reg_rd && reg_addr == `CPWD_A_MODE |=>
    (reg_rdata[6] | reg_rdata[5]) == $past(en_reg)) else $error("watchdog enable state wrong");
  unmapped_zero_a: assert property (reg_rd && reg_addr >= 8'h20 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind cpwd_top cpwd_top_chk #(.N_MOD(N_MOD)) chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .module_output_pin(module_output_pin), .wdog_reset(wdog_reset));
`default_nettype wire

// file: cpwd_pin_load.sv
// load model that times the high phases of one module output pin
`timescale 1ns/10ps
`default_nettype none
module cpwd_pin_load (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clr,
  input  wire logic        pin,
  output var  logic [15:0] high_cycles,
  output var  logic [15:0] last_run
);
  logic [15:0] run_reg;
  always_ff @(posedge clk) begin
    if (rst || clr) high_cycles <= 16'h0000;
    else if (pin) high_cycles <= high_cycles + 16'h0001;
    if (rst) begin
      run_reg  <= 16'h0000;
      last_run <= 16'h0000;
    end else if (pin) run_reg <= run_reg + 16'h0001;
    else begin
      if (run_reg != 16'h0000) last_run <= run_reg;
      run_reg <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// file: cpwd_top_tb.sv
// self-checking bench for the counter array top
`timescale 1ns/10ps
`default_nettype none
`include "cpwd_map.vh"
module cpwd_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        clr = 1'b0;
  logic        tmr0_ovf = 1'b0;
  logic        eci_pin = 1'b1;
  logic        osc_pin = 1'b0;
  wire  [7:0]  reg_rdata;
  wire  [4:0]  pins;
  wire         wdog_reset;
  wire  [47:0] high_cycles;
  wire  [47:0] last_run;
  int          errors = 0;
  int          total_checks = 0;
  int          i;
  int          e;
  logic [7:0]  h;
  logic [7:0]  l;
  cpwd_top #(.N_MOD(5)) DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tmr0_ovf(tmr0_ovf), .cpu_idle(1'b0), .ext_count_pin(eci_pin),
    .ext_osc_pin(osc_pin), .module_output_pin(pins), .wdog_reset(wdog_reset));
  cpwd_pin_load LOAD[2:0] (.clk(clk), .rst(rst), .clr(clr), .pin(pins[2:0]), .high_cycles(high_cycles),
    .last_run(last_run));
  always #2 clk = ~clk;
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string name);
    logic [7:0] d;
    rd(a, d);
    chk(name, exp, d);
  endtask
  // high time counted over one full 8-bit period
  task automatic window;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (256) @(posedge clk);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    test_done;
  end
  initial begin
    e = $urandom(77029);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc(`CPWD_A_CNTL, 8'h00, "counter low");
    rdc(`CPWD_A_MODE, 8'h40, "mode");
    rdc(`CPWD_A_CTRL, 8'h00, "control");
    wr(`CPWD_A_CNTH, 8'h55);
    rdc(`CPWD_A_CNTH, 8'h00, "counter high");
    rdc(8'h40, 8'h00, "unmapped");
    wr(`CPWD_A_MODE, 8'h00);
    wr(`CPWD_A_MODE, 8'h08);
    rdc(`CPWD_A_MODE, 8'h08, "mode free");
    wr(`CPWD_A_CTRL, 8'h40);
    rdc(`CPWD_A_CTRL, 8'h40, "run bit");
    wr(`CPWD_A_CPM, 8'h42);
    wr(`CPWD_A_CPL, 8'h10);
    rdc(`CPWD_A_CPM, 8'h02, "compare off");
    repeat (300) @(posedge clk);
    window;
    chk("duty zero", 16'h0000, high_cycles[15:0]);
    for (i = 0; i < 4; i++) begin
      h = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      wr(`CPWD_A_CPL, 8'($urandom));
      wr(`CPWD_A_CPH, h);
      rdc(`CPWD_A_CPM, 8'h42, "compare on");
      repeat (300) @(posedge clk);
      window;
      chk("duty8", 16'd256 - h, high_cycles[15:0]);
    end
    wr(`CPWD_A_CPM + 8'h02, 8'h46);
    for (i = 0; i < 2; i++) begin
      h = i ? 8'($urandom) : 8'h00;
      wr(`CPWD_A_CPL + 8'h02, 8'h00);
      wr(`CPWD_A_CPH + 8'h02, h);
      repeat (1100) @(posedge clk);
      chk("half period", h ? {8'h00, h} : 16'd256, last_run[47:32]);
    end
    l = 8'($urandom);
    wr(`CPWD_A_CPM + 8'h01, 8'hcb);
    wr(`CPWD_A_CPL + 8'h01, l);
    wr(`CPWD_A_CPH + 8'h01, 8'hff);
    wr(`CPWD_A_CNTL, 8'h00);
    wr(`CPWD_A_CNTH, 8'hfe);
    repeat (900) @(posedge clk);
    chk("pwm16 high", 16'd256 - l, last_run[31:16]);
    rdc(`CPWD_A_CTRL, 8'hc2, "match flag");
    // each source but divide by 12 drives a known number of counter ticks
    for (i = 1; i < 8; i++) begin
      h = 8'(1 + $urandom % 7);
      wr(`CPWD_A_MODE, 8'(i << 1));
      wr(`CPWD_A_CNTL, 8'h00);
      for (e = 0; e < 32 * h; e++) begin
        @(posedge clk);
        tmr0_ovf <= i == 2 && e % 4 == 0;
        eci_pin  <= i != 3 || e[1];
        osc_pin  <= i == 5 && e[0];
      end
      repeat (11) begin
        @(posedge clk);
        tmr0_ovf <= 1'b0;
        eci_pin  <= 1'b1;
        osc_pin  <= 1'b0;
      end
      l = 8'(i == 1 ? 8 * h + 3 : i < 4 ? 8 * h : i == 4 ? 32 * h + 12 : i == 5 ? 2 * h : 0);
      rdc(`CPWD_A_CNTL, l, "timebase count");
    end
    wr(`CPWD_A_CPL + 8'h04, 8'h02);
    wr(`CPWD_A_CNTH, 8'h80);
    wr(`CPWD_A_MODE, 8'h48);
    rd(`CPWD_A_CNTL, l);
    wr(`CPWD_A_CPH + 8'h04, 8'($urandom));
    e = 256 * 2 + 256 - int'(8'(l + 8'h02));
    for (i = 0; i < 1000 && wdog_reset !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i >= e - 3 && i <= e + 3) i = e;
    chk("timeout", 16'(e), 16'(i));
    repeat (3) @(posedge clk);
    wr(`CPWD_A_CTRL, 8'h10);
    #1 chk("forced reset", 16'h0001, {15'h0000, wdog_reset});
    wr(`CPWD_A_MODE, 8'h00);
    wr(`CPWD_A_MODE, 8'h20);
    wr(`CPWD_A_MODE, 8'h00);
    rd(`CPWD_A_MODE, l);
    chk("locked on", 16'h0001, {15'h0000, l[6] | l[5]});
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc(`CPWD_A_CNTL, 8'h00, "counter low again");
    rdc(`CPWD_A_MODE, 8'h40, "mode again");
    test_done;
  end
endmodule
`default_nettype wire
